// *** ddcr_chk.sv ***
// Input check of one channel against the eight-word sequence
`timescale 1ns/1ps
`default_nettype none
module ddcr_chk import ddcr_pkg::*; #(
   parameter int W = CHK_W
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstN,
   // Received data
   input  wire logic         en,
   input  wire logic         frame,
   input  wire logic [W-1:0] data,
   // Programmed words
   input  wire logic [W-1:0] word0,
   input  wire logic [W-1:0] word1,
   output logic              mismatch
);
   logic         frameD_q;
   logic [2:0]   idx_q;
   logic [2:0]   idx;
   logic [W-1:0] expWord;
   logic         frameRise;

   if (W != CHK_W) begin : g_bad_width
      $error("check word width must match the package");
   end

   assign frameRise = frame & ~frameD_q;
   // Word 0 belongs to the cycle of the frame edge
   assign idx = frameRise ? 3'd0 : idx_q;

   always_comb begin
      unique case (idx)
         3'd0:    expWord = word0;
         3'd1:    expWord = word1;
         default: expWord = CHK_WORD_RST[idx];
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         frameD_q <= 1'b0;
         idx_q    <= '0;
         mismatch <= 1'b0;
      end else begin
         frameD_q <= frame;
         idx_q    <= idx + 3'd1;
         mismatch <= en && data != expWord;
      end
   end
endmodule // ddcr_chk
`default_nettype wire

// *** ddcr_host.sv ***
// Host model driving the serial programming pins
`timescale 1ns/1ps
`default_nettype none
module ddcr_host (
   // Clock
   input  wire logic ref_clk,
   // Serial pins
   input  wire logic sdioOut,
   input  wire logic sdioOeN,
   output logic      sclkPin,
   output logic      sdenbNPin,
   output logic      sdioIn
);
   logic hBit = 1'b0;
   logic hDrv = 1'b1;
   // Released line shows the inverse of its last level, as it has no pull resistor
   assign sdioIn = !sdioOeN ? sdioOut : (hDrv ? hBit : !hBit);
   initial begin
      sclkPin   = 1'b0;
      sdenbNPin = 1'b1;
   end
   // Half periods of 8 cycles stay above the 4-cycle minimum of the pin filter
   task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd, output logic [15:0] q);
      logic [23:0] f;
      f = {rd, a, wd};
      q = 16'h0000;
      @(posedge ref_clk);
      #1;
      sdenbNPin = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sclkPin = 1'b0;
         hDrv = !(rd && i < 16);
         if (hDrv) hBit = f[i];
         repeat (8) @(posedge ref_clk);
         #1;
         if (!hDrv) q[i] = sdioIn;
         sclkPin = 1'b1;
         repeat (8) @(posedge ref_clk);
         #1;
      end
      sdenbNPin = 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      sclkPin = 1'b0;
      hDrv = 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
   endtask
endmodule // ddcr_host
`default_nettype wire

// *** ddcr_pkg.sv ***
// Constants of the dual converter configuration register slice
// What this block does
// - The alarm suppression register has one bit per alarm source, a set bit hides that alarm, and it resets to all ones.
// - Bits 15 and 14 hide the zero-check alarms of channels A and B, and bit 13 hides the channel A pointer collision.
// - Bits 4 and 3 hide the input-check mismatch alarms of channels A and B.
// - Bit 5 gates only the force-off of the converter outputs and never touches the alarm pin.
// - While the clock loss flag is high and suppression bit 5 is clear, every converter-bound sample is mid-code.
// - Each channel's input-check alarm fires when received data differs from the eight-word check sequence.
// - The channel A offset sits in bits 12:0, is added to channel A samples in converter steps, and resets to zero.
// - The three-bit read pointer start in bits 15:13 is where the read index loads on a sync, and resets to 100.
// - The channel B offset is applied in converter steps, and any write to its register makes an offset sync pulse.
// - The four-bit full-scale field in bits 15:12 picks one of 16 equal current steps and resets to all ones.
// - Bit 11 of the scale and power register sleeps the fuse bank and bit 8 the temperature sensor, both reset low.
// - Bit 7 enables the conversion clock receiver and resets to one.
// - Bit 6 sleeps converter channel A and bit 5 channel B, both reset low.
// - Check words 0 and 1 are 14 bits in bits 13:0, belong to an eight-word sequence, and reset to fixed values.
package ddcr_pkg;
   localparam int ADDR_W     = 7;
   localparam int DATA_W     = 16;
   localparam int FRAME_BITS = 24;
   localparam int CHK_W      = 14;
   localparam int OFF_W      = 13;

   // Register offsets
   localparam logic [6:0] OFS_ALARM_SUPPRESS = 7'h07;
   localparam logic [6:0] OFS_CHAN_A_OFFSET  = 7'h08;
   localparam logic [6:0] OFS_PTR_CHAN_B_OFS = 7'h09;
   localparam logic [6:0] OFS_SCALE_POWER    = 7'h0A;
   localparam logic [6:0] OFS_RSVD_DEFAULTS  = 7'h0B;
   localparam logic [6:0] OFS_CHECK_WORD0    = 7'h0C;
   localparam logic [6:0] OFS_CHECK_WORD1    = 7'h0D;

   // Values after reset
   localparam logic [15:0] RST_ALARM_SUPPRESS = 16'hFFFF;
   localparam logic [15:0] RST_CHAN_A_OFFSET  = 16'h4000;
   localparam logic [15:0] RST_PTR_CHAN_B_OFS = 16'h8000;
   localparam logic [15:0] RST_SCALE_POWER    = 16'hF080;
   localparam logic [15:0] RST_RSVD_DEFAULTS  = 16'h1111;
   localparam logic [15:0] RST_CHECK_WORD0    = 16'h3A7A;
   localparam logic [15:0] RST_CHECK_WORD1    = 16'h36B6;

   // Field positions
   localparam int SUP_ZERO_A   = 15;
   localparam int SUP_ZERO_B   = 14;
   localparam int SUP_COLL_A   = 13;
   localparam int SUP_FORCE    = 5;
   localparam int SUP_CHK_A    = 4;
   localparam int SUP_CHK_B    = 3;
   localparam int PTR_LSB      = 13;
   localparam int COARSE_LSB   = 12;
   localparam int FUSE_SLEEP   = 11;
   localparam int TSENSE_SLEEP = 8;
   localparam int CLKRECV_EN   = 7;
   localparam int SLEEP_A      = 6;
   localparam int SLEEP_B      = 5;

   // Masks of the stored bits; others read as zero except bit 14 of the A offset; ALARM_SOURCES marks the alarm bits
   localparam logic [15:0] MASK_OFFSET      = 16'h1FFF;
   localparam logic [15:0] MASK_SCALE_POWER = 16'hF9E0;
   localparam logic [15:0] MASK_CHECK       = 16'h3FFF;
   localparam logic [15:0] ALARM_SOURCES    = 16'hFFD8;

   localparam logic [15:0] MID_CODE = 16'h8000;

   // Check words 0 to 7 as they stand after reset; 2 to 7 are fixed here
   localparam logic [13:0] CHK_WORD_RST [0:7] = '{14'h3A7A, 14'h36B6, 14'h2AEA, 14'h0545,
                                                  14'h1A1A, 14'h1616, 14'h2AAA, 14'h06C6};
endpackage

// *** ddcr_sif.sv ***
// Serial programming slave: 24-bit frames, oversampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module ddcr_sif import ddcr_pkg::*; (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rstN,
   // Synchronised serial pins
   input  wire logic              sclk,
   input  wire logic              enableN,
   input  wire logic              sdi,
   output logic                   sdo,
   output logic                   sdoEnN,
   // Register side
   input  wire logic [15:0]       rdData,
   output logic [ADDR_W-1:0]      addr,
   output logic [15:0]            wrData,
   output logic                   wrStb
);
   logic        sclkD_q;
   logic [4:0]  cnt_q;
   logic [22:0] sh_q;
   logic        rd_q;
   logic        ld_q;
   logic [15:0] rdSh_q;
   logic        rise;
   logic        fall;

   assign rise = sclk & ~sclkD_q & ~enableN;
   assign fall = ~sclk & sclkD_q & ~enableN;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) sclkD_q <= 1'b0;
      else sclkD_q <= sclk;
   end

   // Bit count and shift register of the frame
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cnt_q <= '0;
         sh_q  <= '0;
      end else if (enableN) begin
         cnt_q <= '0;
      end else if (rise && cnt_q != 5'(FRAME_BITS)) begin
         cnt_q <= cnt_q + 5'd1;
         sh_q  <= {sh_q[21:0], sdi};
      end
   end

   // Instruction byte: read flag then address
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         addr <= '0;
         rd_q <= 1'b0;
         ld_q <= 1'b0;
      end else begin
         ld_q <= 1'b0;
         if (enableN) begin
            rd_q <= 1'b0;
         end else if (rise && cnt_q == 5'd7) begin
            addr <= {sh_q[5:0], sdi};
            rd_q <= sh_q[6];
            ld_q <= sh_q[6];
         end
      end
   end

   // Write strobe on the last rising edge
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wrData <= '0;
         wrStb  <= 1'b0;
      end else begin
         wrStb <= rise && cnt_q == 5'(FRAME_BITS - 1) && !rd_q;
         if (rise && cnt_q == 5'(FRAME_BITS - 1)) wrData <= {sh_q[14:0], sdi};
      end
   end

   // Read data leaves on falling edges, MSB first
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdSh_q <= '0;
         sdo    <= 1'b0;
      end else if (ld_q) begin
         rdSh_q <= rdData;
      end else if (fall && rd_q && cnt_q >= 5'd8 && cnt_q < 5'(FRAME_BITS)) begin
         sdo    <= rdSh_q[15];
         rdSh_q <= {rdSh_q[14:0], 1'b0};
      end
   end

   assign sdoEnN = ~(rd_q && !enableN && cnt_q >= 5'd8);
endmodule // ddcr_sif
`default_nettype wire

// *** ddcr_tb_top.sv ***
// Self-checking bench of the configuration register slice
`timescale 1ns/1ps
`default_nettype none
module dual_dac_config_registers_tb_top;
   import ddcr_pkg::*;
   typedef struct {logic w; logic [6:0] a; logic [15:0] d; logic [15:0] e;} ddcr_row_t;
   logic ref_clk = 1'b0, nrst = 1'b0, lossFlag = 1'b0, chkEn = 1'b0, frameAlign = 1'b0, seen = 1'b0;
   logic [15:0] alarmRaw = 16'h0000, sampleA = 16'h8000, sampleB = 16'h8000, convA, convB, q;
   logic sclk, sdenbN, sdi, sdo, sdoEnN, alarmPin, offsetSync, fuseSleep, tsenseSleep, clkRecvEn, sleepA, sleepB;
   logic [2:0] ptr;
   logic [3:0] coarse;
   logic [13:0] words [0:7];
   int err_total = 0;
   int cmp_count = 0;
   int syncs = 0;
   ddcr_row_t rows [16] = '{
      '{0, 7'h07, 16'h0000, 16'hFFFF},
      '{0, 7'h08, 16'h0000, 16'h4000},
      '{0, 7'h09, 16'h0000, 16'h8000},
      '{0, 7'h0A, 16'h0000, 16'hF080},
      '{0, 7'h0B, 16'h0000, 16'h1111},
      '{0, 7'h0C, 16'h0000, 16'h3A7A},
      '{0, 7'h0D, 16'h0000, 16'h36B6},
      '{0, 7'h30, 16'h0000, 16'h0000},
      '{1, 7'h0A, 16'hFFFF, 16'hF9E0},
      '{1, 7'h08, 16'hFFFF, 16'h5FFF},
      '{1, 7'h0C, 16'hFFFF, 16'h3FFF},
      '{1, 7'h0D, 16'hC123, 16'h0123},
      '{1, 7'h0B, 16'h1111, 16'h1111},
      '{1, 7'h30, 16'h1234, 16'h0000},
      '{1, 7'h07, 16'h0000, 16'h0000},
      '{1, 7'h09, 16'hFFFF, 16'hFFFF}};
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (alarmPin === 1'b1) seen = 1'b1;
      if (offsetSync === 1'b1) syncs++;
   end
   ddcr_host HOST (.ref_clk(ref_clk), .sdioOut(sdo), .sdioOeN(sdoEnN), .sclkPin(sclk), .sdenbNPin(sdenbN),
                   .sdioIn(sdi));
   ddcr_top DUT (.ref_clk(ref_clk), .nrst(nrst), .sclkPin(sclk), .sdenbNPin(sdenbN), .sdioIn(sdi),
                 .sdioOut(sdo), .sdioOeN(sdoEnN), .alarmRaw(alarmRaw), .clockLossFlag(lossFlag),
                 .alarmPin(alarmPin), .sampleA(sampleA), .sampleB(sampleB), .convA(convA), .convB(convB),
                 .ioCheckEn(chkEn), .frameAlign(frameAlign), .readPtrStart(ptr), .offsetSync(offsetSync),
                 .coarseScale(coarse), .fuseSleep(fuseSleep), .tsenseSleep(tsenseSleep),
                 .clkRecvEn(clkRecvEn), .sleepA(sleepA), .sleepB(sleepB));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      HOST.xfer(1'b0, a, d, q);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Runs 16 samples aligned to a frame rise, flipping one bit of one channel at slot bad
   task automatic run_check(input int bad, input logic onB);
      seen = 1'b0;
      for (int k = 0; k < 16; k++) begin
         chkEn = 1'b1;
         frameAlign = 1'b1;
         sampleA = {words[k % 8] ^ 14'((k == bad && !onB) ? 1 : 0), 2'b00};
         sampleB = {words[k % 8] ^ 14'((k == bad && onB) ? 1 : 0), 2'b00};
         cyc(1);
      end
      chkEn = 1'b0;
      frameAlign = 1'b0;
      cyc(4);
   endtask
   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      // About 50 frames of some 400 cycles each, with the limit at twice that
      #400000;
      err_total++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_of_test();
   end
   initial begin
      for (int k = 0; k < 8; k++) words[k] = CHK_WORD_RST[k];
      words[0] = 14'h3FFF;
      words[1] = 14'h0123;
      cyc(4);
      nrst = 1'b1;
      cyc(8);
      // ----------------------------------------
      // Register table
      // ----------------------------------------
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         HOST.xfer(1'b1, rows[i].a, 16'h0000, q);
         chk(q, rows[i].e);
      end
      $display("test registers done");
      // ----------------------------------------
      // Hand-written cases
      // ----------------------------------------
      wr(7'h0A, 16'h5920);
      chk({4'h0, coarse, fuseSleep, tsenseSleep, clkRecvEn, sleepA, sleepB, 3'h0}, 16'h05C8);
      syncs = 0;
      wr(7'h08, 16'h0010);
      chk(16'(syncs), 16'h0000);
      wr(7'h09, 16'hA005);
      chk(16'(syncs), 16'h0001);
      chk({13'h0, ptr}, 16'h0005);
      sampleA = 16'h1000;
      sampleB = 16'h1000;
      cyc(2);
      chk(convA, 16'h1010);
      chk(convB, 16'h1005);
      sampleA = 16'hFFF8;
      cyc(2);
      chk(convA, 16'hFFFF);
      lossFlag = 1'b1;
      cyc(2);
      chk(convA, MID_CODE);
      chk(convB, MID_CODE);
      wr(7'h07, 16'h0020);
      chk(convB, 16'h1005);
      lossFlag = 1'b0;
      $display("test offsets done");
      foreach (words[b]) begin
         alarmRaw = 16'h0001 << (15 - b);
         wr(7'h07, 16'h0020);
         chk({15'h0, alarmPin}, {15'h0, ALARM_SOURCES[15 - b]});
         wr(7'h07, 16'h0020 | alarmRaw);
         chk({15'h0, alarmPin}, 16'h0000);
      end
      alarmRaw = 16'h0000;
      wr(7'h07, 16'h0020);
      run_check(-1, 1'b0);
      chk({15'h0, seen}, 16'h0000);
      run_check(10, 1'b0);
      chk({15'h0, seen}, 16'h0001);
      wr(7'h07, 16'h0030);
      run_check(10, 1'b0);
      chk({15'h0, seen}, 16'h0000);
      run_check(3, 1'b1);
      chk({15'h0, seen}, 16'h0001);
      $display("test alarms done");
      nrst = 1'b0;
      cyc(4);
      nrst = 1'b1;
      cyc(8);
      chk({ptr, 1'b0, coarse, fuseSleep, tsenseSleep, clkRecvEn, sleepA, sleepB, 3'h0}, 16'h8F20);
      HOST.xfer(1'b1, 7'h07, 16'h0000, q);
      chk(q, RST_ALARM_SUPPRESS);
      $display("test reset done");
      end_of_test();
   end
endmodule // dual_dac_config_registers_tb_top
`default_nettype wire

// *** ddcr_top.sv ***
// Configuration registers 0x07 to 0x0D of the dual converter with their side effects
`timescale 1ns/1ps
`default_nettype none
module ddcr_top import ddcr_pkg::*; #(
   parameter int SAMPLE_W = 16
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   // Serial programming pins
   input  wire logic                sclkPin,
   input  wire logic                sdenbNPin,
   input  wire logic                sdioIn,
   output logic                     sdioOut,
   output logic                     sdioOeN,
   // Alarm sources and clock loss flag
   input  wire logic [15:0]         alarmRaw,
   input  wire logic                clockLossFlag,
   output logic                     alarmPin,
   // Sample path
   input  wire logic [SAMPLE_W-1:0] sampleA,
   input  wire logic [SAMPLE_W-1:0] sampleB,
   output logic [SAMPLE_W-1:0]      convA,
   output logic [SAMPLE_W-1:0]      convB,
   // Input check
   input  wire logic                ioCheckEn,
   input  wire logic                frameAlign,
   // Read pointer start and offset sync
   output logic [2:0]               readPtrStart,
   output logic                     offsetSync,
   // Scale and power controls
   output logic [3:0]               coarseScale,
   output logic                     fuseSleep,
   output logic                     tsenseSleep,
   output logic                     clkRecvEn,
   output logic                     sleepA,
   output logic                     sleepB
);
   if (SAMPLE_W != DATA_W) begin : g_bad_sample
      $error("sample path is built for 16-bit offset-binary codes");
   end

   //------------------------------------------------------------
   // Reset release and pin synchronisers
   //------------------------------------------------------------
   logic       rstS1_q;
   logic       rstN;
   logic [2:0] pinS1_q;
   logic [2:0] pinS2_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rstS1_q <= 1'b0;
         rstN    <= 1'b0;
      end else begin
         rstS1_q <= 1'b1;
         rstN    <= rstS1_q;
      end
   end

   // Enable idles high so a reset does not open a frame
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         pinS1_q <= 3'b010;
         pinS2_q <= 3'b010;
      end else begin
         pinS1_q <= {sclkPin, sdenbNPin, sdioIn};
         pinS2_q <= pinS1_q;
      end
   end

   //------------------------------------------------------------
   // Serial slave
   //------------------------------------------------------------
   logic [ADDR_W-1:0] addr;
   logic [15:0]       wrData;
   logic              wrStb;
   logic [15:0]       rdData;

   ddcr_sif u_sif (
      .clk     (ref_clk),
      .rstN    (rstN),
      .sclk    (pinS2_q[2]),
      .enableN (pinS2_q[1]),
      .sdi     (pinS2_q[0]),
      .sdo     (sdioOut),
      .sdoEnN  (sdioOeN),
      .rdData  (rdData),
      .addr    (addr),
      .wrData  (wrData),
      .wrStb   (wrStb)
   );

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   logic [15:0] alarmSup_q;
   logic [15:0] offA_q;
   logic [15:0] ptrOffB_q;
   logic [15:0] scalePwr_q;
   logic [15:0] rsvd_q;
   logic [15:0] chkWord0_q;
   logic [15:0] chkWord1_q;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [6:0] ofs);
      return a == ofs;
   endfunction

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) alarmSup_q <= RST_ALARM_SUPPRESS;
      else if (wrStb && hit(addr, OFS_ALARM_SUPPRESS)) alarmSup_q <= wrData;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) offA_q <= RST_CHAN_A_OFFSET & MASK_OFFSET;
      else if (wrStb && hit(addr, OFS_CHAN_A_OFFSET)) offA_q <= wrData & MASK_OFFSET;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) ptrOffB_q <= RST_PTR_CHAN_B_OFS;
      else if (wrStb && hit(addr, OFS_PTR_CHAN_B_OFS)) ptrOffB_q <= wrData;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) scalePwr_q <= RST_SCALE_POWER;
      else if (wrStb && hit(addr, OFS_SCALE_POWER)) scalePwr_q <= wrData & MASK_SCALE_POWER;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) rsvd_q <= RST_RSVD_DEFAULTS;
      else if (wrStb && hit(addr, OFS_RSVD_DEFAULTS)) rsvd_q <= wrData;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         chkWord0_q <= RST_CHECK_WORD0;
         chkWord1_q <= RST_CHECK_WORD1;
      end else if (wrStb && hit(addr, OFS_CHECK_WORD0)) begin
         chkWord0_q <= wrData & MASK_CHECK;
      end else if (wrStb && hit(addr, OFS_CHECK_WORD1)) begin
         chkWord1_q <= wrData & MASK_CHECK;
      end
   end

   // Reserved top of channel A offset reads as its fixed default; unmapped reads zero
   always_comb begin
      unique case (addr)
         OFS_ALARM_SUPPRESS: rdData = alarmSup_q;
         OFS_CHAN_A_OFFSET:  rdData = offA_q | (RST_CHAN_A_OFFSET & ~MASK_OFFSET);
         OFS_PTR_CHAN_B_OFS: rdData = ptrOffB_q;
         OFS_SCALE_POWER:    rdData = scalePwr_q;
         OFS_RSVD_DEFAULTS:  rdData = rsvd_q;
         OFS_CHECK_WORD0:    rdData = chkWord0_q;
         OFS_CHECK_WORD1:    rdData = chkWord1_q;
         default:            rdData = 16'h0000;
      endcase
   end

   //------------------------------------------------------------
   // Control outputs
   //------------------------------------------------------------
   assign readPtrStart = ptrOffB_q[PTR_LSB +: 3];
   assign coarseScale  = scalePwr_q[COARSE_LSB +: 4];
   assign fuseSleep    = scalePwr_q[FUSE_SLEEP];
   assign tsenseSleep  = scalePwr_q[TSENSE_SLEEP];
   assign clkRecvEn    = scalePwr_q[CLKRECV_EN];
   assign sleepA       = scalePwr_q[SLEEP_A];
   // Single-channel use leaves this to the host
   assign sleepB       = scalePwr_q[SLEEP_B];

   // Any write to the pointer and channel B register syncs the offset unit
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) offsetSync <= 1'b0;
      else offsetSync <= wrStb && hit(addr, OFS_PTR_CHAN_B_OFS);
   end

   //------------------------------------------------------------
   // Offset correction and input check, per channel
   //------------------------------------------------------------
   logic [OFF_W-1:0]    actOff_q [2];
   logic [SAMPLE_W-1:0] smp [2];
   logic [SAMPLE_W-1:0] conv_q [2];
   logic [OFF_W-1:0]    newOff [2];
   logic [1:0]          mismatch;
   logic                forceMid;

   assign smp[0]    = sampleA;
   assign smp[1]    = sampleB;
   assign newOff[0] = offA_q[OFF_W-1:0];
   assign newOff[1] = ptrOffB_q[OFF_W-1:0];
   assign convA     = conv_q[0];
   assign convB     = conv_q[1];

   // Bit 5 masks only the force-off, not the alarm pin
   assign forceMid = clockLossFlag && !alarmSup_q[SUP_FORCE];

   for (genvar c = 0; c < 2; c++) begin : g_chan
      logic signed [17:0] sum;

      // Both offsets take effect together on the sync, so A can be staged first
      always_ff @(posedge ref_clk or negedge rstN) begin
         if (!rstN) actOff_q[c] <= '0;
         else if (offsetSync) actOff_q[c] <= newOff[c];
      end

      assign sum = $signed({2'b00, smp[c]}) + $signed({{5{actOff_q[c][OFF_W-1]}}, actOff_q[c]});

      // Saturate rather than wrap so a large offset cannot fold the waveform
      always_ff @(posedge ref_clk or negedge rstN) begin
         if (!rstN) conv_q[c] <= MID_CODE;
         else if (forceMid) conv_q[c] <= MID_CODE;
         else if (sum[17]) conv_q[c] <= 16'h0000;
         else if (sum[16]) conv_q[c] <= 16'hFFFF;
         else conv_q[c] <= sum[15:0];
      end

      ddcr_chk u_chk (
         .clk      (ref_clk),
         .rstN     (rstN),
         .en       (ioCheckEn),
         .frame    (frameAlign),
         .data     (smp[c][SAMPLE_W-1 -: CHK_W]),
         .word0    (chkWord0_q[CHK_W-1:0]),
         .word1    (chkWord1_q[CHK_W-1:0]),
         .mismatch (mismatch[c])
      );
   end

   //------------------------------------------------------------
   // Alarm pin
   //------------------------------------------------------------
   logic [15:0] alarmSrc;

   assign alarmSrc = {alarmRaw[15:5], mismatch[0], mismatch[1], alarmRaw[2:0]} & ALARM_SOURCES;

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) alarmPin <= 1'b0;
      else alarmPin <= |(alarmSrc & ~alarmSup_q);
   end

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstN);

   property p_zero_a_alarm;
      alarmRaw[SUP_ZERO_A] && !alarmSup_q[SUP_ZERO_A] |=> alarmPin;
   endproperty
   a_zero_a_alarm: assert property (p_zero_a_alarm) else $error("zero-check A alarm lost");

   property p_chk_b_alarm;
      mismatch[1] && !alarmSup_q[SUP_CHK_B] |=> alarmPin;
   endproperty
   a_chk_b_alarm: assert property (p_chk_b_alarm) else $error("input-check B alarm lost");

   property p_force_bit_quiet;
      (alarmSrc & ~alarmSup_q) == 16'h0000 |=> !alarmPin;
   endproperty
   a_force_bit_quiet: assert property (p_force_bit_quiet) else $error("alarm pin raised by masked source");

   property p_mid_code;
      clockLossFlag && !alarmSup_q[SUP_FORCE] |=> convA == MID_CODE && convB == MID_CODE;
   endproperty
   a_mid_code: assert property (p_mid_code) else $error("output not mid-code on clock loss");

   property p_autosync;
      wrStb && addr == OFS_PTR_CHAN_B_OFS |=> offsetSync ##1 !offsetSync;
   endproperty
   a_autosync: assert property (p_autosync) else $error("write gave no single sync pulse");

   property p_offset_load;
      offsetSync |=> actOff_q[0] == offA_q[OFF_W-1:0] && actOff_q[1] == ptrOffB_q[OFF_W-1:0];
   endproperty
   a_offset_load: assert property (p_offset_load) else $error("offsets not loaded on sync");

   property p_ptr_start;
      wrStb && addr == OFS_PTR_CHAN_B_OFS |=> readPtrStart == $past(wrData[15:13]);
   endproperty
   a_ptr_start: assert property (p_ptr_start) else $error("read pointer start not taken");

   property p_scale_power;
      wrStb && addr == OFS_SCALE_POWER |=> coarseScale == $past(wrData[15:12])
         && {fuseSleep, tsenseSleep, clkRecvEn, sleepA, sleepB}
            == {$past(wrData[11]), $past(wrData[8]), $past(wrData[7]), $past(wrData[6]), $past(wrData[5])};
   endproperty
   a_scale_power: assert property (p_scale_power) else $error("scale or power bit not taken");

   property p_check_word_read;
      addr == OFS_CHECK_WORD0 |-> rdData == {2'b00, chkWord0_q[CHK_W-1:0]};
   endproperty
   a_check_word_read: assert property (p_check_word_read) else $error("check word 0 reads wrong");

   property p_sup_reset;
      $rose(rstN) |-> alarmSup_q == RST_ALARM_SUPPRESS;
   endproperty
   a_sup_reset: assert property (p_sup_reset) else $error("suppression not all ones after reset");
endmodule // ddcr_top
`default_nettype wire
